// ---- eewc_defs.svh ----
// Constants of the wakeup event controller: offsets, field sizes, resets.
// Assumes inclusion by the package, the design files and the testbench.
`ifndef EEWC_DEFS_SVH
`define EEWC_DEFS_SVH

// Line counts: lines 0..29 configurable, 30..31 direct
`define EEWC_NCFG      30
`define EEWC_NLINE     32
`define EEWC_ADDR_W    8

// Register byte offsets
`define EEWC_OFF_RISE  8'h00
`define EEWC_OFF_FALL  8'h04
`define EEWC_OFF_SWT   8'h08
`define EEWC_OFF_RPEND 8'h0c
`define EEWC_OFF_FPEND 8'h10
`define EEWC_OFF_IMASK 8'h14
`define EEWC_OFF_EMASK 8'h18

// Reset values
`define EEWC_RST_SEL   30'h0000_0000
`define EEWC_RST_MASK  32'h0000_0000
`define EEWC_RST_WORD  32'h0000_0000

`endif

// ---- eewc_pkg.sv ----
// Types of the wakeup event controller: one state struct per module.
// Assumes eewc_defs.svh is found on the include path.
`include "eewc_defs.svh"

package eewc_pkg;

  // Whole state of the top module
  typedef struct packed {
    logic [`EEWC_NCFG-1:0]  rise_sel;
    logic [`EEWC_NCFG-1:0]  fall_sel;
    logic [`EEWC_NLINE-1:0] int_mask;
    logic [`EEWC_NLINE-1:0] evt_mask;
    logic [`EEWC_NCFG-1:0]  irq;
    logic                   cpu_event;
    logic                   pmu_wake;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } eewc_top_s;

  // Edge detector of one line
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic dly;
  } eewc_edge_s;

  // Pending flags of one configurable line
  typedef struct packed {
    logic rise;
    logic fall;
  } eewc_pend_s;

endpackage

// ---- eewc_edge.sv ----
// Edge detector of one event line with its re-arm pulse.
// Assumes line_in is asynchronous to clock and enable is from a flop.
`timescale 1ns/10ps
`default_nettype none

module eewc_edge (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Line and arming
  input  wire logic line_in,
  input  wire logic enable,
  // Edge pulses
  output var  logic rise,
  output var  logic fall
);
  import eewc_pkg::*;

  eewc_edge_s q;
  eewc_edge_s d;
  logic       rearm;

  // Delay stage and enable rising edge pulse mask both edge outputs in the cycle enable turns on
  always_comb begin
    d      = q;
    rearm  = q.dly ? 1'b0 : enable;
    d.meta = line_in;
    d.sync = q.meta;
    d.prev = q.sync;
    d.dly  = enable;
    rise   = ~rearm & q.sync & ~q.prev;
    fall   = ~rearm & ~q.sync & q.prev;
  end

  // Only the second stage reads meta
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_arm;
    !enable ##1 enable;
  endsequence

  a_rearm_quiet: assert property (s_arm |-> !rise && !fall)
    else $error("edge seen in re-arm cycle");
endmodule

`default_nettype wire

// ---- eewc_pend.sv ----
// Rising and falling pending flags of one configurable line.
// Assumes set and clear strobes are one-cycle pulses from the clock domain.
`timescale 1ns/10ps
`default_nettype none

module eewc_pend (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Strobes
  input  wire logic set_rise,
  input  wire logic set_fall,
  input  wire logic clr_rise,
  input  wire logic clr_fall,
  // Flags
  output var  logic rise_pend,
  output var  logic fall_pend
);
  import eewc_pkg::*;

  eewc_pend_s q;
  eewc_pend_s d;

  // Set beats clear so a coincident event is kept
  always_comb begin
    d      = q;
    d.rise = set_rise | (q.rise & ~clr_rise);
    d.fall = set_fall | (q.fall & ~clr_fall);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_pend = q.rise;
  assign fall_pend = q.fall;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_set_wins: assert property (set_rise && clr_rise |=> rise_pend)
    else $error("rising set lost to clear");
  a_clr_works: assert property (!set_fall && clr_fall |=> !fall_pend)
    else $error("falling clear ignored");
endmodule

`default_nettype wire

// ---- eewc_top.sv ----
// Wakeup event controller: edge select, pending flags, CPU and wake outputs.
// Assumes an APB-style peripheral bus on clock; lines are asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
`include "eewc_defs.svh"

module eewc_top (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Peripheral bus
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`EEWC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  // Event sources
  input  wire logic [`EEWC_NLINE-1:0]   event_line,
  // CPU and power unit
  output var  logic [`EEWC_NCFG-1:0]    cpu_irq,
  output var  logic                     cpu_event,
  output var  logic                     pmu_wake
);
  import eewc_pkg::*;

  eewc_top_s q;
  eewc_top_s d;

  // Bus phase decode
  logic                     setup;
  logic                     wr;
  logic                     hit;
  logic                     wr_rise;
  logic                     wr_fall;
  logic                     wr_swt;
  logic                     wr_rpend;
  logic                     wr_fpend;
  logic                     wr_imask;
  logic                     wr_emask;

  // Line events
  logic [`EEWC_NLINE-1:0]   rise_p;
  logic [`EEWC_NLINE-1:0]   fall_p;
  logic [`EEWC_NLINE-1:0]   arm;
  logic [`EEWC_NCFG-1:0]    sw_trig;
  logic [`EEWC_NCFG-1:0]    rise_ev;
  logic [`EEWC_NCFG-1:0]    fall_ev;
  logic [`EEWC_NCFG-1:0]    set_rise;
  logic [`EEWC_NCFG-1:0]    set_fall;
  logic [`EEWC_NCFG-1:0]    clr_rise;
  logic [`EEWC_NCFG-1:0]    clr_fall;
  logic [`EEWC_NCFG-1:0]    rpend;
  logic [`EEWC_NCFG-1:0]    fpend;
  logic [`EEWC_NLINE-1:0]   line_ev;

  // Setup phase prepares read data; access phase commits writes
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;

  // Address decode of the seven words
  assign wr_rise  = wr & (paddr == `EEWC_OFF_RISE);
  assign wr_fall  = wr & (paddr == `EEWC_OFF_FALL);
  assign wr_swt   = wr & (paddr == `EEWC_OFF_SWT);
  assign wr_rpend = wr & (paddr == `EEWC_OFF_RPEND);
  assign wr_fpend = wr & (paddr == `EEWC_OFF_FPEND);
  assign wr_imask = wr & (paddr == `EEWC_OFF_IMASK);
  assign wr_emask = wr & (paddr == `EEWC_OFF_EMASK);

  // Soft trigger is a pulse, never stored, so it self-clears
  assign sw_trig = wr_swt ? pwdata[`EEWC_NCFG-1:0] : `EEWC_RST_SEL;

  // Write one to clear pending flags
  assign clr_rise = wr_rpend ? pwdata[`EEWC_NCFG-1:0] : `EEWC_RST_SEL;
  assign clr_fall = wr_fpend ? pwdata[`EEWC_NCFG-1:0] : `EEWC_RST_SEL;

  // Detector is re-armed when one mask bit turns on while the other is off
  assign arm = q.int_mask | q.evt_mask;

  // One synchronised edge detector per line
  genvar gi;
  generate
    for (gi = 0; gi < `EEWC_NLINE; gi++) begin : g_edge
      eewc_edge u_edge (
        .clock   (clock),
        .rst_n   (rst_n),
        .line_in (event_line[gi]),
        .enable  (arm[gi]),
        .rise    (rise_p[gi]),
        .fall    (fall_p[gi])
      );
    end
  endgenerate

  // Edge select and soft trigger on configurable lines
  assign rise_ev = (rise_p[`EEWC_NCFG-1:0] & q.rise_sel) | sw_trig;
  assign fall_ev = fall_p[`EEWC_NCFG-1:0] & q.fall_sel;

  // Only the interrupt mask lets an event become pending
  assign set_rise = rise_ev & q.int_mask[`EEWC_NCFG-1:0];
  assign set_fall = fall_ev & q.int_mask[`EEWC_NCFG-1:0];

  // Pending flags exist for configurable lines only
  generate
    for (gi = 0; gi < `EEWC_NCFG; gi++) begin : g_pend
      eewc_pend u_pend (
        .clock     (clock),
        .rst_n     (rst_n),
        .set_rise  (set_rise[gi]),
        .set_fall  (set_fall[gi]),
        .clr_rise  (clr_rise[gi]),
        .clr_fall  (clr_fall[gi]),
        .rise_pend (rpend[gi]),
        .fall_pend (fpend[gi])
      );
    end
  endgenerate

  // Direct lines use the rising edge only, no select, no pending
  assign line_ev = {rise_p[`EEWC_NLINE-1:`EEWC_NCFG], rise_ev | fall_ev};

  // Next state: registers, outputs and read data
  always_comb begin
    d = q;
    if (wr_rise) begin
      d.rise_sel = pwdata[`EEWC_NCFG-1:0];
    end
    if (wr_fall) begin
      d.fall_sel = pwdata[`EEWC_NCFG-1:0];
    end
    if (wr_imask) begin
      d.int_mask = pwdata;
    end
    if (wr_emask) begin
      d.evt_mask = pwdata;
    end
    // Interrupt follows the pending flags' next value, no extra lag
    d.irq = set_rise | (rpend & ~clr_rise) | set_fall | (fpend & ~clr_fall);
    // Single OR of every event-enabled line
    d.cpu_event = |(line_ev & q.evt_mask);
    // Wake the clocks on any unmasked event or while anything pends
    d.pmu_wake = |(line_ev & arm) | (|d.irq);
    // Zero-wait bus: answer lands in the access phase
    d.pready  = setup;
    d.pslverr = 1'b0;
    d.prdata  = `EEWC_RST_WORD;
    hit       = 1'b1;
    if (setup && !pwrite) begin
      unique case (paddr)
        `EEWC_OFF_RISE:  d.prdata = {2'h0, q.rise_sel};
        `EEWC_OFF_FALL:  d.prdata = {2'h0, q.fall_sel};
        `EEWC_OFF_SWT:   d.prdata = `EEWC_RST_WORD;
        `EEWC_OFF_RPEND: d.prdata = {2'h0, rpend};
        `EEWC_OFF_FPEND: d.prdata = {2'h0, fpend};
        `EEWC_OFF_IMASK: d.prdata = q.int_mask;
        `EEWC_OFF_EMASK: d.prdata = q.evt_mask;
        default:         hit      = 1'b0;
      endcase
    end else if (setup) begin
      unique case (paddr)
        `EEWC_OFF_RISE, `EEWC_OFF_FALL, `EEWC_OFF_SWT,
        `EEWC_OFF_RPEND, `EEWC_OFF_FPEND,
        `EEWC_OFF_IMASK, `EEWC_OFF_EMASK: hit = 1'b1;
        default:                          hit = 1'b0;
      endcase
    end
    // Unmapped words answer with an error and read as zero
    d.pslverr = setup & ~hit;
  end

  // State register; masks and selects reset to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state flops
  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign cpu_irq   = q.irq;
  assign cpu_event = q.cpu_event;
  assign pmu_wake  = q.pmu_wake;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bus read of a given word
  sequence s_read(logic [`EEWC_ADDR_W-1:0] a);
    psel && !penable && !pwrite && paddr == a ##1 psel && penable;
  endsequence

  // Bus write of a given word
  sequence s_write(logic [`EEWC_ADDR_W-1:0] a);
    psel && !penable && pwrite && paddr == a ##1 psel && penable;
  endsequence

  a_swt_sets_pend: assert property (
    (sw_trig & q.int_mask[`EEWC_NCFG-1:0]) != 0 |=>
    ((rpend & $past(set_rise)) == $past(set_rise)))
    else $error("soft trigger did not set rising pending");

  a_mask_gates_pend: assert property (
    ((rpend & ~$past(rpend)) & ~$past(q.int_mask[`EEWC_NCFG-1:0])) == 0)
    else $error("pending set while interrupt masked");

  a_evt_no_pend: assert property (
    (line_ev[`EEWC_NCFG-1:0] & ~q.int_mask[`EEWC_NCFG-1:0]) != 0 |=>
    ((fpend & ~$past(fpend) & $past(~q.int_mask[`EEWC_NCFG-1:0])) == 0))
    else $error("event-only line set falling pending");

  a_edge_select: assert property (
    ((rpend & ~$past(rpend)) & ~$past(rise_ev)) == 0 &&
    ((fpend & ~$past(fpend)) & ~$past(fall_p[`EEWC_NCFG-1:0] & q.fall_sel)) == 0)
    else $error("pending set without selected edge");

  a_soft_rising: assert property (
    wr_swt && pwdata[3] && q.int_mask[3] && !q.rise_sel[3] |=> rpend[3])
    else $error("soft trigger needs no rising select");

  a_event_or: assert property (
    ##1 cpu_event == $past(|(line_ev & q.evt_mask)))
    else $error("cpu event not the OR of enabled events");

  a_irq_pend: assert property (cpu_irq == (rpend | fpend))
    else $error("interrupt differs from pending flags");

  a_direct_fall: assert property (
    fall_p[`EEWC_NLINE-1] && !rise_p[`EEWC_NLINE-1] &&
    line_ev[`EEWC_NCFG-1:0] == 0 && rise_p[`EEWC_NCFG] == 0 |=> !cpu_event)
    else $error("direct line fired on a falling edge");

  a_swt_reads_zero: assert property (s_read(`EEWC_OFF_SWT) |-> prdata == 0 && pready)
    else $error("soft trigger read not zero");

  a_sel_rsvd_zero: assert property (
    s_read(`EEWC_OFF_RISE) or s_read(`EEWC_OFF_FALL) |-> prdata[31:30] == 0)
    else $error("select reserved bits not zero");

  a_mask_write: assert property (
    s_write(`EEWC_OFF_IMASK) |=> q.int_mask == $past(pwdata))
    else $error("interrupt mask write lost");

  // Bus answers: zero wait, and an error always comes with ready and zero data
  a_bus_zero_wait: assert property (##1 pready == $past(setup))
    else $error("ready not one cycle after setup");

  a_err_with_ready: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");

  a_unmapped_err: assert property (s_read(8'h1c) |-> pslverr)
    else $error("unmapped word answered without error");

  // Register writes land in the cycle after the access phase
  // Checked from the bus side so a broken decode cannot hide behind the flags
  a_rsel_write: assert property (
    s_write(`EEWC_OFF_RISE) |=> q.rise_sel == $past(pwdata[`EEWC_NCFG-1:0]))
    else $error("rising select write lost");

  a_fsel_write: assert property (
    s_write(`EEWC_OFF_FALL) |=> q.fall_sel == $past(pwdata[`EEWC_NCFG-1:0]))
    else $error("falling select write lost");

  a_emask_write: assert property (
    s_write(`EEWC_OFF_EMASK) |=> q.evt_mask == $past(pwdata))
    else $error("event mask write lost");

  // Write one clears a flag unless an edge sets it in that very cycle
  a_rpend_clear: assert property (
    s_write(`EEWC_OFF_RPEND) ##0 (set_rise & pwdata[`EEWC_NCFG-1:0]) == 0 |=>
    (rpend & $past(pwdata[`EEWC_NCFG-1:0])) == 0)
    else $error("rising pending not cleared by write one");

  a_fpend_clear: assert property (
    s_write(`EEWC_OFF_FPEND) ##0 (set_fall & pwdata[`EEWC_NCFG-1:0]) == 0 |=>
    (fpend & $past(pwdata[`EEWC_NCFG-1:0])) == 0)
    else $error("falling pending not cleared by write one");

  // A flag only ever falls where software wrote a one
  a_pend_keep: assert property (
    ##1 ((((~rpend & $past(rpend)) & ~$past(clr_rise)) == 0) &&
         (((~fpend & $past(fpend)) & ~$past(clr_fall)) == 0)))
    else $error("pending flag fell without a write one");

  // A selected edge on an unmasked line always becomes pending
  a_rise_pends: assert property (
    (rise_p[`EEWC_NCFG-1:0] & q.rise_sel & q.int_mask[`EEWC_NCFG-1:0]) != 0 |=>
    (rpend & $past(rise_p[`EEWC_NCFG-1:0] & q.rise_sel & q.int_mask[`EEWC_NCFG-1:0])) ==
    $past(rise_p[`EEWC_NCFG-1:0] & q.rise_sel & q.int_mask[`EEWC_NCFG-1:0]))
    else $error("selected rising edge not pending");

  a_fall_pends: assert property (
    (fall_p[`EEWC_NCFG-1:0] & q.fall_sel & q.int_mask[`EEWC_NCFG-1:0]) != 0 |=>
    (fpend & $past(fall_p[`EEWC_NCFG-1:0] & q.fall_sel & q.int_mask[`EEWC_NCFG-1:0])) ==
    $past(fall_p[`EEWC_NCFG-1:0] & q.fall_sel & q.int_mask[`EEWC_NCFG-1:0]))
    else $error("selected falling edge not pending");

  // Direct lines wake the clocks and may raise the CPU event
  a_direct_wake: assert property (
    (rise_p[`EEWC_NLINE-1:`EEWC_NCFG] & arm[`EEWC_NLINE-1:`EEWC_NCFG]) != 0
    |=> pmu_wake)
    else $error("direct line edge did not wake");

  a_direct_event: assert property (
    (rise_p[`EEWC_NLINE-1:`EEWC_NCFG] & q.evt_mask[`EEWC_NLINE-1:`EEWC_NCFG]) != 0 |=> cpu_event)
    else $error("direct line edge gave no cpu event");

  // Wake stays up as long as any interrupt is asserted
  a_irq_wake: assert property (cpu_irq != 0 |-> pmu_wake)
    else $error("interrupt asserted without wake");
endmodule

`default_nettype wire

// ---- eewc_src_model.sv ----
// Far-side model: event sources on the lines, CPU event and power-unit listener.
// Assumes it is driven through its tasks by the testbench on the same clock.
`timescale 1ns/10ps
`default_nettype none

module eewc_src_model (
  // Clock
  input  wire logic        clock,
  // Outputs of the controller seen by CPU and power unit
  input  wire logic        cpu_event,
  input  wire logic        pmu_wake,
  // Event sources
  output var  logic [31:0] event_line,
  // Observations
  output var  int          n_event,
  output var  logic        wake_seen
);
  initial begin
    event_line = 32'h0000_0000;
    n_event    = 0;
    wake_seen  = 1'b0;
  end

  // Sources change just after an edge, as a synchronous peripheral would
  task automatic drive(input int idx, input logic val);
    @(posedge clock);
    event_line[idx] <= val;
  endtask

  task automatic clear_wake();
    @(posedge clock);
    wake_seen <= 1'b0;
  endtask

  // Count CPU event pulses; remember any wake request since the last clear
  always @(posedge clock) begin
    if (cpu_event === 1'b1) begin
      n_event <= n_event + 1;
    end
    if (pmu_wake === 1'b1) begin
      wake_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- extended_event_wakeup_ctrl_tb.sv ----
// Self-checking testbench of the wakeup event controller.
// Assumes eewc_top and eewc_src_model are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`include "eewc_defs.svh"

module extended_event_wakeup_ctrl_tb;
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] event_line;
  logic [29:0] cpu_irq;
  logic        cpu_event;
  logic        pmu_wake;
  int          n_event;
  logic        wake_seen;
  int          n_mismatch;
  int          samples_checked;

  eewc_top dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_line(event_line),
    .cpu_irq(cpu_irq), .cpu_event(cpu_event), .pmu_wake(pmu_wake));

  eewc_src_model src (.clock(clock), .cpu_event(cpu_event), .pmu_wake(pmu_wake),
    .event_line(event_line), .n_event(n_event), .wake_seen(wake_seen));

  // 40 MHz clock
  always #12.5 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus transfer; the answer is taken while it stands in the access cycle
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    // Answer taken at the edge that ends the access phase, before it moves
    @(posedge clock);
    r   = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    bus(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, experr}, {31'h0, e});
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(25 * 4000);
    n_mismatch++;
    conclude();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values of every register, then an unmapped place
    for (int a = 0; a < 7; a++) rd(8'(a * 4), 32'h0000_0000, 1'b0);
    rd(8'h1c, 32'h0000_0000, 1'b1);
    // Reserved select bits read zero; masks hold all 32 bits
    wr(`EEWC_OFF_RISE, 32'hffff_ffff);
    rd(`EEWC_OFF_RISE, 32'h3fff_ffff, 1'b0);
    wr(`EEWC_OFF_FALL, 32'hffff_ffff);
    rd(`EEWC_OFF_FALL, 32'h3fff_ffff, 1'b0);
    wr(`EEWC_OFF_IMASK, 32'hffff_ffff);
    rd(`EEWC_OFF_IMASK, 32'hffff_ffff, 1'b0);
    wr(`EEWC_OFF_EMASK, 32'hffff_ffff);
    rd(`EEWC_OFF_EMASK, 32'hffff_ffff, 1'b0);
    // Line 0 rising, 1 falling, 2 both, 4 rising as CPU event only
    wr(`EEWC_OFF_RISE, 32'h0000_0015);
    wr(`EEWC_OFF_FALL, 32'h0000_0006);
    wr(`EEWC_OFF_IMASK, 32'h4000_000f);
    wr(`EEWC_OFF_EMASK, 32'h8000_0010);
    repeat (4) @(posedge clock);
    for (int i = 0; i < 5; i++) src.drive(i, 1'b1);
    settle();
    chk("cpu_irq", 32'h0000_0005, {2'b00, cpu_irq});
    chk("cpu_event count", 32'h1, 32'(n_event));
    rd(`EEWC_OFF_RPEND, 32'h0000_0005, 1'b0);
    rd(`EEWC_OFF_FPEND, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 5; i++) src.drive(i, 1'b0);
    settle();
    chk("cpu_irq", 32'h0000_0007, {2'b00, cpu_irq});
    chk("cpu_event count", 32'h1, 32'(n_event));
    rd(`EEWC_OFF_FPEND, 32'h0000_0006, 1'b0);
    // Writing zero leaves flags, writing one clears them
    wr(`EEWC_OFF_RPEND, 32'h0000_0000);
    wr(`EEWC_OFF_FPEND, 32'h0000_0000);
    rd(`EEWC_OFF_RPEND, 32'h0000_0005, 1'b0);
    rd(`EEWC_OFF_FPEND, 32'h0000_0006, 1'b0);
    wr(`EEWC_OFF_RPEND, 32'h0000_0005);
    wr(`EEWC_OFF_FPEND, 32'h0000_0006);
    settle();
    chk("cpu_irq", 32'h0000_0000, {2'b00, cpu_irq});
    chk("pmu_wake", 32'h0, {31'h0, pmu_wake});
    // The clear commits at the very edge the synchronised rise sets the flag
    src.drive(0, 1'b1);
    wr(`EEWC_OFF_RPEND, 32'h0000_0001);
    settle();
    rd(`EEWC_OFF_RPEND, 32'h0000_0001, 1'b0);
    wr(`EEWC_OFF_RPEND, 32'h0000_0001);
    src.drive(0, 1'b0);
    // Soft trigger on a line with no edge selected
    wr(`EEWC_OFF_SWT, 32'h0000_0008);
    settle();
    chk("cpu_irq", 32'h0000_0008, {2'b00, cpu_irq});
    rd(`EEWC_OFF_RPEND, 32'h0000_0008, 1'b0);
    rd(`EEWC_OFF_SWT, 32'h0000_0000, 1'b0);
    wr(`EEWC_OFF_RPEND, 32'h0000_0008);
    // Soft trigger on a masked line leaves nothing pending
    wr(`EEWC_OFF_SWT, 32'h0000_0020);
    settle();
    rd(`EEWC_OFF_RPEND, 32'h0000_0000, 1'b0);
    // Direct lines: 30 wakes only, 31 also raises the CPU event, rising edge only, never pending
    src.clear_wake();
    src.drive(30, 1'b1);
    settle();
    chk("wake_seen", 32'h1, {31'h0, wake_seen});
    chk("cpu_irq", 32'h0000_0000, {2'b00, cpu_irq});
    rd(`EEWC_OFF_RPEND, 32'h0000_0000, 1'b0);
    src.drive(31, 1'b1);
    settle();
    chk("cpu_event count", 32'h2, 32'(n_event));
    src.drive(31, 1'b0);
    settle();
    chk("cpu_event count", 32'h2, 32'(n_event));
    // A second reset in mid-run brings the rising select and interrupt mask back to zero
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(`EEWC_OFF_RISE, 32'h0000_0000, 1'b0);
    rd(`EEWC_OFF_IMASK, 32'h0000_0000, 1'b0);
    chk("cpu_irq", 32'h0000_0000, {2'b00, cpu_irq});
    conclude();
  end
endmodule
`default_nettype wire
